// ==== shared/count_timebase_regs.vh ====
// special function register addresses, field positions, reset values and divider counts
`ifndef COUNT_TIMEBASE_REGS_VH
`define COUNT_TIMEBASE_REGS_VH

// special function register addresses
`define ADDR_COUNTER_LOW_BYTE     8'he9
`define ADDR_COUNTER_HIGH_BYTE    8'hf9
`define ADDR_ARRAY_MODE_REGISTER  8'hd9

// array_mode_register field positions
`define MODE_IDLE_HALT_BIT        7
`define MODE_WATCHDOG_BIT         6
`define MODE_OVERFLOW_FLAG_BIT    4
`define MODE_TIMEBASE_MSB         3
`define MODE_TIMEBASE_LSB         1
`define MODE_OVERFLOW_IRQ_EN_BIT  0

// reset values
`define MODE_RESET                8'h40
`define COUNTER_RESET             16'h0000

// timebase_select codes
`define TB_SYS_DIV12              3'h0
`define TB_SYS_DIV4               3'h1
`define TB_TIMER0_OVERFLOW        3'h2
`define TB_EXT_PIN_FALL           3'h3
`define TB_SYS_CLOCK              3'h4
`define TB_EXT_OSC_DIV8           3'h5

// divider counts
`define DIV_SYS_12                4'hc
`define DIV_SYS_4                 4'h4
`define DIV_EXT_OSC_8             4'h8
`define DIVIDER_WIDTH             4

`endif

// ==== hw/edge_sync.v ====
// two-flop synchroniser for an outside level with rise and fall pulses
`timescale 1ns/100ps
module edge_sync
(
   // clock and reset
   input  wire i_clk,
   input  wire i_rst,
   // asynchronous input
   input  wire i_async,
   // synchronised level and edge pulses
   output wire o_level,
   output wire o_rise,
   output wire o_fall
);

   reg meta;
   reg stable;
   reg stable_d;

   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta     <= 1'b1;
         stable   <= 1'b1;
         stable_d <= 1'b1;
      end
      else
      begin
         meta     <= i_async;
         stable   <= meta;
         stable_d <= stable;
      end
   end

   // one pulse per edge; reset high so a pin idling high at release counts nothing
   assign o_level = stable;
   assign o_rise  = stable & ~stable_d;
   assign o_fall  = ~stable & stable_d;

endmodule

// ==== hw/tick_divider.v ====
// divides a stream of enable pulses by a fixed ratio into one tick pulse
`timescale 1ns/100ps
`include "count_timebase_regs.vh"
module tick_divider
#(
   parameter [`DIVIDER_WIDTH-1:0] DIVIDE = `DIV_SYS_4
)
(
   // clock and reset
   input  wire i_clk,
   input  wire i_rst,
   // input pulses to divide
   input  wire i_pulse,
   // one pulse for every DIVIDE input pulses
   output wire o_tick
);

   reg [`DIVIDER_WIDTH-1:0] count;

   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         count <= {`DIVIDER_WIDTH{1'b0}};
      else if (i_pulse)
      begin
         if (count == DIVIDE - 1'b1)
            count <= {`DIVIDER_WIDTH{1'b0}};
         else
            count <= count + 1'b1;
      end
   end

   assign o_tick = i_pulse & (count == DIVIDE - 1'b1);

endmodule

// ==== hw/counter_timebase.v ====
// counter array 16-bit counter, timebase selection, snapshot and overflow flag
// What this block does
// R1: the count is a 16-bit up-counter readable and writable as two byte halves
// R2: reading the low byte latches the high byte; the next high read returns it
// R3: software should read the low byte before the high byte for a coherent value
// R4: reads of either byte never disturb counting
// R5: a three-bit select picks one of six count sources; 11x is reserved
// R6: count on each falling edge of the external pin, which toggles at most clock/4
// R7: the external oscillator is synchronised and then divided by eight before counting
// R8: wrapping from all ones to zero sets the overflow flag
// R9: the interrupt request follows the flag only while its enable bit is one
// R10: the flag stays set across interrupt entry; software clears it
// R11: idle halts counting only while the idle-control bit is one
// R12: after reset the watchdog is on and it blocks writes to array registers, except to the watchdog bit itself
// R13: the pin is sampled on the system clock; one count per falling edge
// R14: a reserved select holds the counter and raises no overflow
`timescale 1ns/100ps
`include "count_timebase_regs.vh"
module counter_timebase
(
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // special function register port
   input  wire [7:0]  i_sfr_addr,
   input  wire        i_sfr_wr,
   input  wire        i_sfr_rd,
   input  wire [7:0]  i_sfr_wdata,
   output wire [7:0]  o_sfr_rdata,
   // processor state and other timers
   input  wire        i_cpu_idle,
   input  wire        i_timer0_overflow,
   // outside pins
   input  wire        i_external_count_pin,
   input  wire        i_ext_osc,
   // count and status toward the capture/compare modules
   output wire [15:0] o_count,
   output wire        o_count_tick,
   output wire        o_counter_overflow_irq,
   output wire        o_watchdog_active
);

   // register state
   reg  [15:0] count;
   reg  [7:0]  snapshot;
   reg         snapshot_valid;
   reg  [7:0]  rdata;
   reg  [2:0]  timebase_select;
   reg         idle_halt_control;
   reg         overflow_irq_enable;
   reg         counter_overflow_flag;
   reg         watchdog_function;

   // decoded accesses
   wire        hit_low;
   wire        hit_high;
   wire        hit_mode;
   wire        wr_low;
   wire        wr_high;
   wire        wr_mode;
   wire        rd_low;
   wire        rd_high;
   wire        rd_mode;
   wire        write_allowed;

   // timebase pulses
   wire        tick_sys_div12;
   wire        tick_sys_div4;
   wire        pin_fall;
   wire        osc_rise;
   wire        tick_ext_osc;
   reg         source_tick;
   wire        halted;
   wire        advance;
   wire        wraps;
   reg  [7:0]  mode_value;
   reg  [7:0]  next_rdata;
   wire        reserved_select;
   // next-state values
   reg  [15:0] next_count;
   reg         next_overflow_flag;

   // reset image of the mode register, split into its fields below
   localparam [7:0] MODE_RST = `MODE_RESET;

   assign hit_low  = (i_sfr_addr == `ADDR_COUNTER_LOW_BYTE);
   assign hit_high = (i_sfr_addr == `ADDR_COUNTER_HIGH_BYTE);
   assign hit_mode = (i_sfr_addr == `ADDR_ARRAY_MODE_REGISTER);

   // while the watchdog runs, the counter and all mode fields but the watchdog bit are locked
   assign write_allowed = ~watchdog_function; // R12

   assign wr_low  = i_sfr_wr & hit_low & write_allowed;
   assign wr_high = i_sfr_wr & hit_high & write_allowed;
   assign wr_mode = i_sfr_wr & hit_mode;
   assign rd_low  = i_sfr_rd & hit_low;
   assign rd_high = i_sfr_rd & hit_high;
   assign rd_mode = i_sfr_rd & hit_mode;

   // fixed-ratio dividers of the system clock
   tick_divider
   #(
      .DIVIDE (`DIV_SYS_12)
   )
   u_div12
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pulse (1'b1),
      .o_tick  (tick_sys_div12)
   );

   tick_divider
   #(
      .DIVIDE (`DIV_SYS_4)
   )
   u_div4
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pulse (1'b1),
      .o_tick  (tick_sys_div4)
   );

   // external pin: two flops, then a single-cycle fall pulse
   edge_sync u_pin_sync
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_external_count_pin),
      .o_level (),
      .o_rise  (),
      .o_fall  (pin_fall)
   ); // R13

   // oscillator edges are brought into the system domain before dividing,
   // so it must run below half the system clock; one domain is kept
   edge_sync u_osc_sync
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_ext_osc),
      .o_level (),
      .o_rise  (osc_rise),
      .o_fall  ()
   ); // R7

   tick_divider
   #(
      .DIVIDE (`DIV_EXT_OSC_8)
   )
   u_div_osc
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pulse (osc_rise),
      .o_tick  (tick_ext_osc)
   ); // R7

   // count source selection
   always @*
   begin
      case (timebase_select) // R5
         `TB_SYS_DIV12:       source_tick = tick_sys_div12;
         `TB_SYS_DIV4:        source_tick = tick_sys_div4;
         `TB_TIMER0_OVERFLOW: source_tick = i_timer0_overflow;
         `TB_EXT_PIN_FALL:    source_tick = pin_fall; // R6
         `TB_SYS_CLOCK:       source_tick = 1'b1;
         `TB_EXT_OSC_DIV8:    source_tick = tick_ext_osc; // R7
         default:             source_tick = 1'b0; // R14
      endcase
   end

   assign halted  = i_cpu_idle & idle_halt_control; // R11
   // reserved codes also gate the advance, not only the source mux
   assign reserved_select = (timebase_select[2:1] == 2'h3); // R14
   // a software write to either byte takes priority over counting that cycle
   assign advance = source_tick & ~halted & ~reserved_select & ~wr_low & ~wr_high;
   assign wraps   = advance & (count == 16'hffff); // R8

   // next counter value; reads have no part in it
   always @*
   begin
      next_count = count;
      if (wr_low)
         next_count = {count[15:8], i_sfr_wdata}; // R1
      else if (wr_high)
         next_count = {i_sfr_wdata, count[7:0]}; // R1
      else if (advance)
         next_count = count + 16'h0001; // R4
   end

   // the counter
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         count <= `COUNTER_RESET;
      else
         count <= next_count;
   end

   // high-byte snapshot taken on every low-byte read
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         snapshot       <= 8'h00;
         snapshot_valid <= 1'b0;
      end
      else if (rd_low)
      begin
         snapshot       <= count[15:8]; // R2
         snapshot_valid <= 1'b1;
      end
      else if (rd_high)
         snapshot_valid <= 1'b0;
   end

   // mode register fields
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         idle_halt_control   <= MODE_RST[`MODE_IDLE_HALT_BIT];
         watchdog_function   <= MODE_RST[`MODE_WATCHDOG_BIT]; // R12
         timebase_select     <= MODE_RST[`MODE_TIMEBASE_MSB:`MODE_TIMEBASE_LSB];
         overflow_irq_enable <= MODE_RST[`MODE_OVERFLOW_IRQ_EN_BIT];
      end
      else if (wr_mode)
      begin
         // the watchdog bit itself stays writable so software can unlock
         watchdog_function <= i_sfr_wdata[`MODE_WATCHDOG_BIT];
         if (write_allowed)
         begin
            idle_halt_control   <= i_sfr_wdata[`MODE_IDLE_HALT_BIT];
            timebase_select     <= i_sfr_wdata[`MODE_TIMEBASE_MSB:`MODE_TIMEBASE_LSB];
            overflow_irq_enable <= i_sfr_wdata[`MODE_OVERFLOW_IRQ_EN_BIT];
         end
      end
   end

   // overflow flag: hardware set wins over a software clear in the same cycle
   always @*
   begin
      next_overflow_flag = counter_overflow_flag;
      if (wraps)
         next_overflow_flag = 1'b1; // R8
      else if (wr_mode & write_allowed)
         next_overflow_flag = i_sfr_wdata[`MODE_OVERFLOW_FLAG_BIT]; // R10
   end

   // flag register, left set across interrupt entry
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         counter_overflow_flag <= MODE_RST[`MODE_OVERFLOW_FLAG_BIT];
      else
         counter_overflow_flag <= next_overflow_flag;
   end

   always @*
   begin
      mode_value                            = 8'h00;
      mode_value[`MODE_IDLE_HALT_BIT]       = idle_halt_control;
      mode_value[`MODE_WATCHDOG_BIT]        = watchdog_function;
      mode_value[`MODE_OVERFLOW_FLAG_BIT]   = counter_overflow_flag;
      mode_value[`MODE_TIMEBASE_MSB:`MODE_TIMEBASE_LSB] = timebase_select;
      mode_value[`MODE_OVERFLOW_IRQ_EN_BIT] = overflow_irq_enable;
   end

   // read data mux; unmapped addresses read zero
   always @*
   begin
      next_rdata = rdata;
      if (rd_low)
         next_rdata = count[7:0];
      else if (rd_high)
         next_rdata = snapshot_valid ? snapshot : count[15:8]; // R2
      else if (rd_mode)
         next_rdata = mode_value;
      else if (i_sfr_rd)
         next_rdata = 8'h00;
   end

   // registered so read data stands until the next read strobe
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         rdata <= 8'h00;
      else
         rdata <= next_rdata;
   end

   assign o_sfr_rdata            = rdata;
   assign o_count                = count;
   assign o_count_tick           = advance;
   // level request, never cleared by the core's interrupt entry
   assign o_counter_overflow_irq = counter_overflow_flag & overflow_irq_enable; // R9
   assign o_watchdog_active      = watchdog_function;

endmodule

// ==== test/counter_timebase_assertions.sv ====
// assertions on the counter timebase register port and count
`timescale 1ns/100ps
`include "count_timebase_regs.vh"
module counter_timebase_assertions
(
   // clock and reset
   input wire        i_clk,
   input wire        i_rst,
   // register port
   input wire [7:0]  i_sfr_addr,
   input wire        i_sfr_wr,
   input wire        i_sfr_rd,
   input wire [7:0]  i_sfr_wdata,
   input wire [7:0]  o_sfr_rdata,
   // count and status
   input wire [15:0] o_count,
   input wire        o_count_tick,
   input wire        o_counter_overflow_irq,
   input wire        o_watchdog_active
);
   wire      lo  = i_sfr_addr == `ADDR_COUNTER_LOW_BYTE;
   wire      hi  = i_sfr_addr == `ADDR_COUNTER_HIGH_BYTE;
   wire      wcn = i_sfr_wr && (lo || hi);
   reg       pend;
   reg [7:0] snap;
   // only an unconsumed low read sends the next high read to the snapshot
   always @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         pend <= 1'b0;
         snap <= 8'h00;
      end
      else if (i_sfr_rd && lo)
      begin
         pend <= 1'b1;
         snap <= o_count[15:8];
      end
      else if (i_sfr_rd && hi)
         pend <= 1'b0;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence low_read_s;
      i_sfr_rd && lo;
   endsequence
   sequence snap_read_s;
      i_sfr_rd && hi && pend;
   endsequence
   read_low_a: assert property (low_read_s |=> o_sfr_rdata == $past(o_count[7:0]))
      else $error("low read data wrong");
   snap_high_a: assert property (snap_read_s |=> o_sfr_rdata == $past(snap))
      else $error("high read missed snapshot");
   rdata_hold_a: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
      else $error("read data moved without read");
   count_step_a: assert property (o_count_tick && !wcn |=> o_count == $past(o_count) + 16'h0001)
      else $error("count did not step by one");
   count_hold_a: assert property (!o_count_tick && !wcn |=> $stable(o_count))
      else $error("count moved without tick");
   write_load_a: assert property (i_sfr_wr && lo && !o_watchdog_active
      |=> o_count[7:0] == $past(i_sfr_wdata))
      else $error("low byte write not loaded");
   wdog_reset_a: assert property ($past(i_rst) |-> o_watchdog_active)
      else $error("watchdog off after reset");
   wdog_lock_a: assert property (o_watchdog_active && wcn && !o_count_tick |=> $stable(o_count))
      else $error("locked write changed count");
   wrap_irq_a: assert property ($rose(o_counter_overflow_irq)
      |-> o_count == 16'h0000 || $past(i_sfr_wr))
      else $error("interrupt without wrap");
endmodule
bind counter_timebase counter_timebase_assertions counter_timebase_assertions_i
(
   .i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
   .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
   .o_count(o_count), .o_count_tick(o_count_tick),
   .o_counter_overflow_irq(o_counter_overflow_irq), .o_watchdog_active(o_watchdog_active)
);

// ==== test/ext_source.sv ====
// outside count sources: external pin falls and oscillator
`timescale 1ns/100ps
module ext_source
(
   // clock and run control
   input  wire i_clk,
   input  wire i_run,
   // driven pins
   output wire o_pin,
   output wire o_osc
);
   reg [6:0] c = 7'h00;
   always @(posedge i_clk)
      c <= i_run ? c + 7'h01 : 7'h00;
   // pin idles high; one fall per 8 clocks keeps it under clk/4
   assign o_pin = i_run ? c[2] : 1'b1;
   // 16 rises per run, a whole number of divide-by-8 periods, so no leftover
   assign o_osc = (i_run && c < 7'h40) ? c[1] : 1'b0;
endmodule

// ==== test/tb.sv ====
// self-checking bench for the counter timebase through its register port
`timescale 1ns/100ps
`include "count_timebase_regs.vh"
module tb;
   localparam [7:0] MD = `ADDR_ARRAY_MODE_REGISTER;
   localparam [7:0] LO = `ADDR_COUNTER_LOW_BYTE;
   localparam [7:0] HI = `ADDR_COUNTER_HIGH_BYTE;
   reg         i_clk = 1'b0;
   reg         i_rst = 1'b1;
   reg  [7:0]  a = 8'h00;
   reg         wr = 1'b0;
   reg         rdq = 1'b0;
   reg  [7:0]  wd = 8'h00;
   reg         idle = 1'b0;
   reg         t0 = 1'b0;
   reg         run = 1'b0;
   wire        pin;
   wire        osc;
   wire [7:0]  rdata;
   wire [15:0] cnt;
   wire        irq;
   wire        wdog;
   integer     n_mismatch = 0;
   integer     checks = 0;
   integer     k;
   reg  [7:0]  rd;
   reg  [15:0] c0;
   counter_timebase counter_timebase_i
   (
      .i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(a), .i_sfr_wr(wr), .i_sfr_rd(rdq),
      .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .i_cpu_idle(idle), .i_timer0_overflow(t0),
      .i_external_count_pin(pin), .i_ext_osc(osc), .o_count(cnt), .o_count_tick(),
      .o_counter_overflow_irq(irq), .o_watchdog_active(wdog)
   );
   ext_source ext_source_i (.i_clk(i_clk), .i_run(run), .o_pin(pin), .o_osc(osc));
   initial forever #12.5 i_clk = ~i_clk;
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk16(input [15:0] g, input [15:0] e, input [63:0] w);
      begin
         checks = checks + 1;
         if (g !== e)
         begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t %0s got %h exp %h", $time, w, g, e);
         end
      end
   endtask
   task chk8(input [7:0] g, input [7:0] e, input [63:0] w);
      chk16({8'h00, g}, {8'h00, e}, w);
   endtask
   task sfr_wr(input [7:0] ad, input [7:0] d);
      begin
         @(posedge i_clk);
         a <= ad;
         wd <= d;
         wr <= 1'b1;
         @(posedge i_clk);
         wr <= 1'b0;
         #1;
      end
   endtask
   task sfr_rd(input [7:0] ad);
      begin
         @(posedge i_clk);
         a <= ad;
         rdq <= 1'b1;
         @(posedge i_clk);
         rdq <= 1'b0;
         #1 rd = rdata;
      end
   endtask
   // 96 clocks is a whole number of every divider period
   task measure(input [2:0] code, input [15:0] e);
      begin
         sfr_wr(MD, {4'h0, code, 1'b0});
         @(posedge i_clk);
         run <= 1'b1;
         #1 c0 = cnt;
         for (k = 0; k < 96; k = k + 1)
         begin
            @(posedge i_clk);
            t0 <= (k % 8 == 0);
            run <= (k < 95);
         end
         #1 chk16(cnt - c0, e, "rate");
      end
   endtask
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      sfr_rd(MD);
      chk8(rd, `MODE_RESET, "mode rst");
      chk8({7'h00, wdog}, 8'h01, "wdog");
      sfr_wr(HI, 8'h55);
      chk8(cnt[15:8], 8'h00, "locked");
      sfr_wr(MD, 8'h0c);
      sfr_rd(MD);
      chk8(rd, 8'h00, "mode lck");
      $display("test reset done");
      measure(3'h0, 16'h0008);
      measure(3'h1, 16'h0018);
      measure(3'h2, 16'h000c);
      measure(3'h3, 16'h000c);
      measure(3'h4, 16'h0060);
      measure(3'h5, 16'h0002);
      measure(3'h6, 16'h0000);
      measure(3'h7, 16'h0000);
      $display("test timebase done");
      sfr_wr(MD, 8'h0c);
      sfr_wr(HI, 8'hff);
      sfr_wr(LO, 8'hfe);
      chk16(cnt, 16'hfffe, "load");
      sfr_wr(MD, 8'h09);
      repeat (4) @(posedge i_clk);
      sfr_rd(MD);
      chk8(rd, 8'h19, "flag");
      chk8({7'h00, irq}, 8'h01, "irq");
      sfr_wr(MD, 8'h18);
      chk8({7'h00, irq}, 8'h00, "irq off");
      sfr_rd(MD);
      chk8(rd, 8'h18, "flag on");
      sfr_wr(MD, 8'h08);
      sfr_rd(MD);
      chk8(rd, 8'h08, "flag clr");
      $display("test overflow done");
      sfr_wr(MD, 8'h0c);
      sfr_wr(HI, 8'h00);
      sfr_wr(LO, 8'hf0);
      sfr_wr(MD, 8'h08);
      sfr_rd(LO);
      repeat (24) @(posedge i_clk);
      sfr_rd(HI);
      chk8(rd, 8'h00, "snap");
      sfr_rd(HI);
      chk8(rd, 8'h01, "live");
      $display("test snapshot done");
      sfr_wr(MD, 8'h88);
      @(posedge i_clk);
      idle <= 1'b1;
      #1 c0 = cnt;
      repeat (20) @(posedge i_clk);
      #1 chk16(cnt - c0, 16'h0000, "idle");
      sfr_wr(MD, 8'h08);
      @(posedge i_clk);
      #1 c0 = cnt;
      repeat (20) @(posedge i_clk);
      #1 chk16(cnt - c0, 16'h0014, "idle run");
      $display("test idle done");
      summarize;
   end
endmodule
